// ==== hw/uart9_pkg.sv ====
// package: register map, field positions, reset values and timing for the nine-bit uart
package uart9_pkg;
	localparam logic [11:0] OFF_CONTROL   = 12'h000;
	localparam logic [11:0] OFF_STATUS    = 12'h004;
	localparam logic [11:0] OFF_DATA      = 12'h008;
	localparam logic [11:0] OFF_OWN_ADDR  = 12'h00c;
	localparam logic [11:0] OFF_ADDR_MASK = 12'h010;
	localparam logic [11:0] OFF_IRQ_STAT  = 12'h014;
	localparam logic [11:0] OFF_IRQ_EN    = 12'h018;
	localparam logic [11:0] OFF_IRQ_CLR   = 12'h01c;
	localparam logic [11:0] OFF_BAUD      = 12'h020;

	// control register fields
	localparam int CTL_MODE_LO   = 6;
	localparam int CTL_FILTER    = 5;
	localparam int CTL_RX_EN     = 4;
	localparam int CTL_TX_NINTH  = 3;
	localparam int CTL_RX_NINTH  = 2;
	localparam int CTL_TX_DONE   = 1;
	localparam int CTL_RX_DONE   = 0;
	// status register fields
	localparam int STS_DBL_BUF   = 7;
	localparam int STS_EOS_SEL   = 6;
	localparam int STS_LATE_SEL  = 5;
	localparam int STS_BUF_FULL  = 1;
	localparam int STS_TX_BUSY   = 0;
	// interrupt bits
	localparam int IRQ_TX        = 0;
	localparam int IRQ_RX        = 1;

	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [15:0] RST_BAUD     = 16'h0043;
	localparam logic [31:0] RD_UNMAPPED  = 32'h00000000;

	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_8BIT  = 2'h1;
	localparam logic [1:0] MODE_9A    = 2'h2;
	localparam logic [1:0] MODE_9B    = 2'h3;

	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] SAMPLE_POINT    = 4'h7;
	localparam logic [3:0] BITS_9          = 4'h9;
	localparam logic [3:0] BITS_8          = 4'h8;
endpackage

// ==== hw/tx_buf_if.sv ====
// interface: transmit double buffer between control logic and shifter
`timescale 1ns/1ps
interface tx_buf_if;
	logic       load;
	logic [8:0] load_char;
	logic       busy;
	logic       stop_start;
	logic       stop_end;
	logic       take;
	logic       nine_bits;
	logic       tick;
	logic       ninth_live_en;
	logic       ninth_live;
	modport ctl (output load, output load_char, output nine_bits, output tick,
		output ninth_live_en, output ninth_live,
		input busy, input stop_start, input stop_end, input take);
	modport shf (input load, input load_char, input nine_bits, input tick,
		input ninth_live_en, input ninth_live,
		output busy, output stop_start, output stop_end, output take);
endinterface

// ==== hw/uart9_tx_shifter.sv ====
// module: transmit shift register with start, data, ninth and stop bit sequencing
`timescale 1ns/1ps
module uart9_tx_shifter
	import uart9_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	tx_buf_if.shf     bus,
	output logic      txd_o
);
	typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP} tx_state_t;
	tx_state_t  state_reg;
	logic [3:0] phase_reg;
	logic [3:0] bit_reg;
	logic [8:0] shift_reg;
	logic       last_phase;

	assign last_phase     = bus.tick && (phase_reg == OVERSAMPLE_LAST);
	assign bus.busy       = (state_reg != ST_IDLE);
	// stop bit begins when the last data bit ends
	assign bus.stop_start = (state_reg == ST_DATA) && last_phase &&
		(bit_reg == (bus.nine_bits ? BITS_9 : BITS_8) - 4'h1);
	assign bus.stop_end   = (state_reg == ST_STOP) && last_phase;
	// a waiting character is taken when idle or at the end of the stop bit
	assign bus.take       = bus.load && ((state_reg == ST_IDLE) || bus.stop_end);

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			phase_reg <= 4'h0;
			bit_reg   <= 4'h0;
			shift_reg <= 9'h1ff;
			txd_o     <= 1'b1;
		end else begin
			if (bus.tick && state_reg != ST_IDLE)
				phase_reg <= phase_reg + 4'h1;
			unique case (state_reg)
				ST_IDLE: begin
					txd_o <= 1'b1;
					if (bus.take) begin
						shift_reg <= bus.load_char;
						state_reg <= ST_START;
						phase_reg <= 4'h0;
						txd_o     <= 1'b0;
					end
				end
				ST_START: if (last_phase) begin
					state_reg <= ST_DATA;
					bit_reg   <= 4'h0;
					txd_o     <= shift_reg[0];
				end
				ST_DATA: if (last_phase) begin
					if (bus.stop_start) begin
						state_reg <= ST_STOP;
						txd_o     <= 1'b1;
					end else begin
						bit_reg   <= bit_reg + 4'h1;
						shift_reg <= {1'b1, shift_reg[8:1]};
						// without double buffer the ninth bit is taken as it goes out
						txd_o     <= (bit_reg == 4'h7 && bus.ninth_live_en) ?
							bus.ninth_live : shift_reg[1]; // [RL1] [RL2]
					end
				end
				ST_STOP: if (last_phase) begin
					if (bus.take) begin
						shift_reg <= bus.load_char;
						state_reg <= ST_START;
						txd_o     <= 1'b0;
					end else begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end
endmodule // uart9_tx_shifter

// ==== hw/uart9_top.sv ====
// module: nine-bit uart with double buffer, transmit irq timing and address recognition
// Summary of operation
// RL1: ninth bit may precede or follow data write
// RL2: software holds ninth bit until transmit interrupt
// RL3: double buffer captures ninth bit with data
// RL4: empty buffer write loads shifter, interrupts immediately
// RL5: end select 0 gives no final interrupt
// RL6: end select 1 interrupts at stop start/end
// RL7: queued byte interrupts at stop start/end
// RL8: nine-bit modes move nine bits, store ninth
// RL9: filtering passes only frames with ninth one
// RL10: master marks addresses one, data zero
// RL11: filter ignored in mode 0, zero in 1
// RL12: address match sets receive flag automatically
// RL13: given address uses mask bits only
// RL14: broadcast is own or mask, zeros ignored
// RL15: reset clears own address and mask
// RL16: double buffer enable bit 7, resets zero
// RL17: receive loads only when flag clear, qualified
// RL18: address compare on eight bits, ninth one
// RL19: buffer holds one character, empties on move
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module uart9_top
	import uart9_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        rxd_i,
	output logic             txd_o,
	output logic             irq_o
);
	tx_buf_if tb ();

	logic [1:0]  mode_reg;
	logic        filter_reg;
	logic        rx_en_reg;
	logic        tx_ninth_bit;
	logic        rx_ninth_bit;
	logic        tx_done_reg;
	logic        rx_done_flag;
	logic        double_buffer_enable;
	logic        eos_sel_reg;
	logic        late_sel_reg;
	logic [7:0]  own_address_reg;
	logic [7:0]  address_mask_reg;
	logic [7:0]  data_reg;
	logic [8:0]  buf_char_reg;
	logic        buf_full_reg;
	logic        last_irq_pending_reg;
	logic [15:0] baud_reg;
	logic [15:0] baud_cnt_reg;
	logic [1:0]  irq_stat_reg;
	logic [1:0]  irq_en_reg;
	logic        wr_en;
	logic        rd_en;
	logic        tx_event;
	logic        rx_event;
	logic        data_write;

	function automatic logic sel(input logic [11:0] off);
		sel = (paddr_i == off);
	endfunction

	assign wr_en      = psel_i && penable_i && pwrite_i;
	assign rd_en      = psel_i && penable_i && !pwrite_i;
	assign pready_o   = 1'b1;
	assign pslverr_o  = 1'b0;
	assign data_write = wr_en && sel(OFF_DATA);

	// baud tick at sixteen times the bit rate
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			baud_cnt_reg <= 16'h0000;
		else if (baud_cnt_reg >= baud_reg)
			baud_cnt_reg <= 16'h0000;
		else
			baud_cnt_reg <= baud_cnt_reg + 16'h0001;
	end
	assign tb.tick      = (baud_cnt_reg >= baud_reg);
	assign tb.nine_bits = mode_reg[1]; // [RL8]
	assign tb.ninth_live_en = !double_buffer_enable; // [RL1]
	assign tb.ninth_live    = tx_ninth_bit; // [RL2]

	// double buffer: without it the ninth bit is read live as it is sent
	assign tb.load      = double_buffer_enable ? buf_full_reg : buf_full_reg;
	assign tb.load_char = double_buffer_enable ? buf_char_reg
		: {tx_ninth_bit, buf_char_reg[7:0]}; // [RL1] [RL2]

	uart9_tx_shifter u_shf (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.bus     (tb),
		.txd_o   (txd_o)
	);

	// buffer capture: ninth bit sampled at the data write
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_char_reg <= 9'h000;
			buf_full_reg <= 1'b0;
		end else if (data_write) begin
			buf_char_reg <= {tx_ninth_bit, pwdata_i[7:0]}; // [RL3]
			buf_full_reg <= 1'b1;
		end else if (tb.take) begin
			buf_full_reg <= 1'b0; // [RL19]
		end
	end

	// transmit interrupt timing
	always_comb begin
		tx_event = 1'b0;
		if (!double_buffer_enable) begin
			tx_event = tb.stop_end;
		end else begin
			if (tb.take && !tb.busy)
				tx_event = 1'b1; // [RL4]
			if (last_irq_pending_reg || buf_full_reg) begin
				if (late_sel_reg ? tb.stop_end : tb.stop_start)
					tx_event = 1'b1; // [RL6] [RL7]
			end
		end
	end

	// with double buffer, a character loaded from the buffer has no final interrupt unless end select is set
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			last_irq_pending_reg <= 1'b0;
		else if (tb.take)
			last_irq_pending_reg <= eos_sel_reg; // [RL5]
		else if (tb.stop_end)
			last_irq_pending_reg <= 1'b0;
	end

	// receiver
	logic       rx_sync1_reg;
	logic       rx_sync2_reg;
	logic       rx_act_reg;
	logic [3:0] rx_phase_reg;
	logic [3:0] rx_bit_reg;
	logic [9:0] rx_shift_reg;
	logic       rx_sample;
	logic       rx_final;
	logic [3:0] rx_bits;
	logic [7:0] rx_byte;
	logic       rx_nine;
	logic       addr_match;
	logic       rx_accept;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_sync1_reg <= 1'b1;
			rx_sync2_reg <= 1'b1;
		end else begin
			rx_sync1_reg <= rxd_i;
			rx_sync2_reg <= rx_sync1_reg;
		end
	end

	assign rx_bits   = mode_reg[1] ? BITS_9 : BITS_8;
	assign rx_sample = rx_act_reg && tb.tick && (rx_phase_reg == SAMPLE_POINT);
	assign rx_final  = rx_sample && (rx_bit_reg == rx_bits + 4'h1);

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_act_reg   <= 1'b0;
			rx_phase_reg <= 4'h0;
			rx_bit_reg   <= 4'h0;
			rx_shift_reg <= 10'h000;
		end else if (!rx_act_reg) begin
			if (rx_en_reg && !rx_sync2_reg) begin
				rx_act_reg   <= 1'b1;
				rx_phase_reg <= 4'h0;
				rx_bit_reg   <= 4'h0;
			end
		end else if (tb.tick) begin
			rx_phase_reg <= rx_phase_reg + 4'h1;
			if (rx_sample) begin
				rx_shift_reg <= {rx_sync2_reg, rx_shift_reg[9:1]};
				rx_bit_reg   <= rx_bit_reg + 4'h1;
				if ((rx_bit_reg == 4'h0 && rx_sync2_reg) || rx_final)
					rx_act_reg <= 1'b0;
			end
		end
	end

	// read before the final shift: the newest data bit sits at the top, start bit below data
	assign rx_byte = mode_reg[1] ? rx_shift_reg[8:1] : rx_shift_reg[9:2];
	assign rx_nine = mode_reg[1] ? rx_shift_reg[9] : rx_sync2_reg;

	// given: masked bits must match; broadcast: zeros of own or mask ignored
	always_comb begin
		logic [7:0] bcast;
		logic       given_ok;
		logic       bcast_ok;
		bcast    = own_address_reg | address_mask_reg; // [RL14]
		given_ok = ((rx_byte ^ own_address_reg) & address_mask_reg) == 8'h00; // [RL13]
		bcast_ok = ((~rx_byte) & bcast) == 8'h00; // [RL14]
		addr_match = given_ok || bcast_ok; // [RL18]
	end

	always_comb begin
		rx_accept = 1'b0;
		if (rx_final && !rx_done_flag) begin
			if (!filter_reg || mode_reg == MODE_SHIFT)
				rx_accept = 1'b1; // [RL11]
			else if (mode_reg[1])
				rx_accept = rx_nine && addr_match; // [RL9] [RL12] [RL17] [RL18]
			else
				rx_accept = rx_nine;
		end
	end
	assign rx_event = rx_accept;

	// registers written by software
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_reg             <= MODE_SHIFT;
			filter_reg           <= 1'b0;
			rx_en_reg            <= 1'b0;
			tx_ninth_bit         <= 1'b0;
			double_buffer_enable <= 1'b0; // [RL16]
			eos_sel_reg          <= 1'b0;
			late_sel_reg         <= 1'b0;
			own_address_reg      <= RST_BYTE; // [RL15]
			address_mask_reg     <= RST_BYTE; // [RL15]
			baud_reg             <= RST_BAUD;
			irq_en_reg           <= 2'h0;
		end else if (wr_en) begin
			if (sel(OFF_CONTROL)) begin
				mode_reg     <= pwdata_i[CTL_MODE_LO+1:CTL_MODE_LO];
				filter_reg   <= pwdata_i[CTL_FILTER];
				rx_en_reg    <= pwdata_i[CTL_RX_EN];
				tx_ninth_bit <= pwdata_i[CTL_TX_NINTH];
			end
			if (sel(OFF_STATUS)) begin
				double_buffer_enable <= pwdata_i[STS_DBL_BUF]; // [RL16]
				eos_sel_reg          <= pwdata_i[STS_EOS_SEL];
				late_sel_reg         <= pwdata_i[STS_LATE_SEL];
			end
			if (sel(OFF_OWN_ADDR))
				own_address_reg <= pwdata_i[7:0];
			if (sel(OFF_ADDR_MASK))
				address_mask_reg <= pwdata_i[7:0];
			if (sel(OFF_BAUD))
				baud_reg <= pwdata_i[15:0];
			if (sel(OFF_IRQ_EN))
				irq_en_reg <= pwdata_i[1:0];
		end
	end

	// hardware-set flags; set wins over a software clear
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_done_reg  <= 1'b0;
			rx_done_flag <= 1'b0;
			rx_ninth_bit <= 1'b0;
			data_reg     <= RST_BYTE;
			irq_stat_reg <= 2'h0;
		end else begin
			if (rx_accept) begin
				data_reg     <= rx_byte;
				rx_ninth_bit <= rx_nine; // [RL8]
			end
			if (wr_en && sel(OFF_CONTROL)) begin
				tx_done_reg  <= pwdata_i[CTL_TX_DONE] | tx_event;
				rx_done_flag <= pwdata_i[CTL_RX_DONE] | rx_event;
			end else begin
				tx_done_reg  <= tx_done_reg | tx_event;
				rx_done_flag <= rx_done_flag | rx_event; // [RL12]
			end
			if (wr_en && sel(OFF_IRQ_CLR))
				irq_stat_reg <= (irq_stat_reg & ~pwdata_i[1:0]) | {rx_event, tx_event};
			else
				irq_stat_reg <= irq_stat_reg | {rx_event, tx_event};
		end
	end

	assign irq_o = |(irq_stat_reg & irq_en_reg);

	// read data is registered in the setup cycle and valid in the access phase
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= RD_UNMAPPED;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= RD_UNMAPPED;
			if (sel(OFF_CONTROL))
				prdata_o <= {24'h000000, mode_reg, filter_reg, rx_en_reg,
					tx_ninth_bit, rx_ninth_bit, tx_done_reg, rx_done_flag};
			if (sel(OFF_STATUS))
				prdata_o <= {24'h000000, double_buffer_enable, eos_sel_reg,
					late_sel_reg, 3'h0, buf_full_reg, tb.busy};
			if (sel(OFF_DATA))
				prdata_o <= {24'h000000, data_reg};
			if (sel(OFF_OWN_ADDR))
				prdata_o <= {24'h000000, own_address_reg};
			if (sel(OFF_ADDR_MASK))
				prdata_o <= {24'h000000, address_mask_reg};
			if (sel(OFF_IRQ_STAT))
				prdata_o <= {30'h00000000, irq_stat_reg};
			if (sel(OFF_IRQ_EN))
				prdata_o <= {30'h00000000, irq_en_reg};
			if (sel(OFF_BAUD))
				prdata_o <= {16'h0000, baud_reg};
		end
	end
endmodule // uart9_top

// ==== bench/uart9_assertions.sv ====
// checker: port-level properties of the nine-bit uart
`timescale 1ns/1ps
module uart9_assertions
	import uart9_pkg::*;
(
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        rxd_i,
	input wire logic        txd_o,
	input wire logic        irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire wr_acc = psel_i && penable_i && pwrite_i;
	wire rd_set = psel_i && !penable_i && !pwrite_i;
	zero_wait_a: assert property (psel_i && penable_i |-> pready_o && !pslverr_o)
		else $error("access not answered at once");
	unmapped_read_a: assert property (rd_set && paddr_i == 12'h024 |=> prdata_o == RD_UNMAPPED)
		else $error("unmapped read not zero");
	reset_idle_a: assert property ($rose(rst_n_i) |-> txd_o && !irq_o)
		else $error("line or irq not idle after reset");
	start_bit_a: assert property ($fell(txd_o) |-> !txd_o [*8])
		else $error("start bit too short");
	irq_masked_a: assert property (wr_acc && paddr_i == OFF_IRQ_EN && pwdata_i[1:0] == 2'b00
		|=> !irq_o [*2]) else $error("irq high while masked");
	own_readback_a: assert property (wr_acc && paddr_i == OFF_OWN_ADDR ##2
		rd_set && paddr_i == OFF_OWN_ADDR
		|=> {24'h0, prdata_o[7:0]} == ($past(pwdata_i, 3) & 32'h000000ff))
		else $error("own address readback wrong");
	irq_bits_a: assert property (rd_set && paddr_i == OFF_IRQ_STAT |=> prdata_o[31:2] == 30'h0)
		else $error("irq status spare bits set");
	status_spare_a: assert property (rd_set && paddr_i == OFF_STATUS |=> prdata_o[4:2] == 3'h0)
		else $error("status spare bits set");
endmodule // uart9_assertions

// ==== bench/uart9_peer.sv ====
// partner: remote node on the shared serial line, nine-bit frames
`timescale 1ns/1ps
module uart9_peer #(
	parameter int BIT = 16
) (
	input  wire logic mclk_i,
	input  wire logic txd_i,
	output logic      rxd_o
);
	logic [8:0] got[$];
	logic [8:0] sh;
	initial rxd_o = 1'b1;
	always begin
		@(negedge txd_i);
		repeat (BIT / 2) @(posedge mclk_i);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge mclk_i);
			sh[i] = txd_i;
		end
		repeat (BIT) @(posedge mclk_i);
		got.push_back(sh);
	end
	// caller marks addresses with a one in the ninth bit, data with a zero
	task automatic send(input logic [8:0] c);
		rxd_o <= 1'b0;
		repeat (BIT) @(posedge mclk_i);
		for (int i = 0; i < 9; i++) begin
			rxd_o <= c[i];
			repeat (BIT) @(posedge mclk_i);
		end
		rxd_o <= 1'b1;
		repeat (BIT) @(posedge mclk_i);
	endtask
endmodule // uart9_peer

// ==== bench/uart_ninth_bit_multiproc_addr_tb.sv ====
// testbench: registers, transmit irq timing and address filter of the nine-bit uart
`timescale 1ns/1ps
module uart_ninth_bit_multiproc_addr_tb
	import uart9_pkg::*;
;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o, rxd_i, txd_o, irq_o;
	logic [31:0] q;
	logic [11:0] za[5] = '{OFF_OWN_ADDR, OFF_ADDR_MASK, OFF_STATUS, OFF_IRQ_STAT, 12'h024};
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	logic [31:0] dut_ctl = 32'hb0;
	uart9_top dut_u (.mclk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .rxd_i, .txd_o, .irq_o);
	uart9_peer p_u (.mclk_i, .txd_i(txd_o), .rxd_o(rxd_i));
	always #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) cyc <= cyc + 1;
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
		end while (pready_o !== 1'b1);
		q = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic tx_case(input logic db, eos, late, two, input int lo, hi);
		int t0;
		wr(OFF_CONTROL, 32'h80);
		wr(OFF_STATUS, {24'h0, db, eos, late, 5'h00});
		wr(OFF_IRQ_CLR, 32'h1);
		if (db) begin
			wr(OFF_CONTROL, 32'h88);
			wr(OFF_DATA, 32'h5a);
			t0 = cyc;
			rd(OFF_IRQ_STAT);
			chk(q[IRQ_TX], 1'b1);
			wr(OFF_IRQ_CLR, 32'h1);
		end else begin
			wr(OFF_DATA, 32'h5a);
			t0 = cyc;
			wr(OFF_CONTROL, 32'h88);
		end
		if (two) begin
			wr(OFF_CONTROL, 32'h80);
			wr(OFF_DATA, 32'ha5);
			rd(OFF_STATUS);
			chk(q[STS_BUF_FULL], 1'b1);
		end
		while (irq_o !== 1'b1 && cyc - t0 < 300) @(posedge mclk_i);
		chk(cyc - t0 >= lo && cyc - t0 <= hi, 1'b1);
		wr(OFF_IRQ_CLR, 32'h1);
		do rd(OFF_STATUS); while (q[STS_TX_BUSY] !== 1'b0 && cyc - t0 < 900);
		repeat (4) @(posedge mclk_i);
		chk(p_u.got.size(), 32'(two) + 32'h1);
		chk(p_u.got.pop_front(), 9'h15a);
		if (two) chk(p_u.got.pop_front(), 9'h0a5);
	endtask
	task automatic rx_case(input logic [8:0] c, input logic ok, input logic [8:0] ed,
		input logic clr);
		p_u.send(c);
		repeat (4) @(posedge mclk_i);
		rd(OFF_CONTROL);
		chk(q[CTL_RX_DONE], ok);
		chk(irq_o, ok);
		if (ok) chk(q[CTL_RX_NINTH], ed[8]);
		rd(OFF_DATA);
		if (ok) chk(q[7:0], ed[7:0]);
		if (clr) begin
			wr(OFF_CONTROL, dut_ctl);
			wr(OFF_IRQ_CLR, 32'h2);
			chk(irq_o, 1'b0);
		end
	endtask
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
		foreach (za[i]) begin
			rd(za[i]);
			chk(q, 32'h0);
		end
		wr(OFF_BAUD, 32'h0);
		wr(OFF_IRQ_EN, 32'h1);
		tx_case(1'b0, 1'b0, 1'b0, 1'b0, 171, 186);
		tx_case(1'b1, 1'b0, 1'b0, 1'b0, 300, 300);
		tx_case(1'b1, 1'b1, 1'b0, 1'b0, 158, 168);
		tx_case(1'b1, 1'b1, 1'b1, 1'b0, 174, 184);
		tx_case(1'b1, 1'b0, 1'b0, 1'b1, 158, 168);
		tx_case(1'b1, 1'b0, 1'b1, 1'b1, 174, 184);
		wr(OFF_IRQ_EN, 32'h2);
		wr(OFF_CONTROL, dut_ctl);
		rx_case(9'h137, 1'b1, 9'h137, 1'b1);
		rx_case(9'h037, 1'b0, 9'h000, 1'b1);
		wr(OFF_OWN_ADDR, 32'hc0);
		rd(OFF_OWN_ADDR);
		wr(OFF_ADDR_MASK, 32'hfd);
		rx_case(9'h0c2, 1'b0, 9'h000, 1'b1);
		rx_case(9'h1c1, 1'b0, 9'h000, 1'b1);
		rx_case(9'h1c2, 1'b1, 9'h1c2, 1'b0);
		rx_case(9'h1ff, 1'b1, 9'h1c2, 1'b1);
		rx_case(9'h1ff, 1'b1, 9'h1ff, 1'b1);
		dut_ctl = 32'h70;
		wr(OFF_CONTROL, dut_ctl);
		rx_case(9'h1a5, 1'b1, 9'h1a5, 1'b1);
		dut_ctl = 32'h90;
		wr(OFF_CONTROL, dut_ctl);
		rx_case(9'h03c, 1'b1, 9'h03c, 1'b0);
		wr(OFF_IRQ_EN, 32'h0);
		chk(irq_o, 1'b0);
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		err_total++;
		complete_run;
	end
endmodule // uart_ninth_bit_multiproc_addr_tb
bind uart9_top uart9_assertions chk_u (.mclk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rxd_i, .txd_o, .irq_o);
